// >>> rtl/swa_alu.sv
// Execute stage: subword arithmetic, shifts, multiply-accumulate and
// per-thread flag registers. Operands arrive from the issuing thread's
// register file; result is registered one cycle later with its write enable.
//
// Contract
// - 16-bit sum wraps; flag 6 set on carry out, else cleared.
// - 8-bit sum per byte; flag 6 low carry, flag 7 high carry.
// - 16-bit difference wraps; flag 6 set when negative.
// - 8-bit difference per byte; flags 6 and 7 show lane borrows.
// - Average halves the sum; clears flag 6, and flag 7 in 8-bit.
// - 16-bit difference halved; flag 6 set when negative.
// - 8-bit difference halved per lane; flags 6 and 7 show borrows.
// - Logical right shift fills zeros; flags unchanged.
// - Arithmetic right shift copies sign bit; flags unchanged.
// - Left shift inserts zeros, writes destination; flags unchanged.
// - Rotate left by count; flags unchanged.
// - Subword operations have 8-bit two-lane and 16-bit forms.
// - Multiply-accumulate adds low or high byte product to destination.
// - Multiply-accumulate wraps and sets flag 6 on overflow, else clears.
// - Flag bit 0 always one; writes to it silently ignored.
`timescale 1ns/100ps
module swa_alu #(
  parameter int THREADS = swa_pkg::THREADS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic issueValid,
  input wire logic [swa_pkg::TID_W-1:0] issueThread,
  input wire swa_pkg::swa_op_t issueOp,
  input wire logic byteMode,
  input wire logic [swa_pkg::WORD_W-1:0] firstSourceOperand,
  input wire logic [swa_pkg::WORD_W-1:0] secondSourceOperand,
  input wire logic [swa_pkg::WORD_W-1:0] destOperand,
  input wire logic [swa_pkg::FLAG_W-1:0] flagWriteData,
  input wire logic [swa_pkg::TID_W-1:0] flagReadThread,
  output logic [swa_pkg::WORD_W-1:0] resultData,
  output logic resultWrite,
  output logic [swa_pkg::TID_W-1:0] resultThread,
  output logic [swa_pkg::FLAG_W-1:0] flagReadData
);
  localparam int W = swa_pkg::WORD_W;
  localparam int B = swa_pkg::BYTE_W;
  localparam int F6 = swa_pkg::FLAG_LOW_CARRY;
  localparam int F7 = swa_pkg::FLAG_HIGH_CARRY;

  // ==========================================================
  // Add/subtract lanes, chained in 16-bit mode
  logic isSub;
  logic loCin;
  logic hiCin;
  logic [B-1:0] loSum;
  logic [B-1:0] hiSum;
  logic loCout;
  logic hiCout;

  always_comb begin
    isSub = (issueOp == swa_pkg::OP_DIFFERENCE) ||
            (issueOp == swa_pkg::OP_SUBWORD_DIFFERENCE_HALVED);
    loCin = isSub;
    hiCin = byteMode ? isSub : loCout;
  end

  swa_lane #(.W(B)) uLaneLo (
    .laneA(firstSourceOperand[B-1:0]),
    .laneB(secondSourceOperand[B-1:0]),
    .subtract(isSub),
    .carryIn(loCin),
    .sum(loSum),
    .carryOut(loCout)
  );

  swa_lane #(.W(B)) uLaneHi (
    .laneA(firstSourceOperand[W-1:B]),
    .laneB(secondSourceOperand[W-1:B]),
    .subtract(isSub),
    .carryIn(hiCin),
    .sum(hiSum),
    .carryOut(hiCout)
  );

  // ==========================================================
  // Lane overflow and underflow
  // Borrow is the inverse of carry when subtracting via complement
  logic loOver;
  logic hiOver;
  always_comb begin
    loOver = isSub ? ~loCout : loCout;
    hiOver = isSub ? ~hiCout : hiCout;
  end

  // ==========================================================
  // Shifters: one 16-bit unit and two byte units sharing a count
  // Both widths run every cycle; the result case below only selects
  logic [1:0] shiftKind;
  logic [W-1:0] shiftWord;
  logic [W-1:0] shiftBytes;

  always_comb begin
    unique case (issueOp)
      swa_pkg::OP_ARITH_RIGHT_SHIFT: shiftKind = 2'h1;
      swa_pkg::OP_LOGICAL_LEFT_SHIFT: shiftKind = 2'h2;
      swa_pkg::OP_ROTATE_LEFT: shiftKind = 2'h3;
      default: shiftKind = 2'h0;
    endcase
  end

  swa_shift_lane #(.W(W), .CW(swa_pkg::CNT16_W)) uShiftWord (
    .value(firstSourceOperand),
    .count(secondSourceOperand[swa_pkg::CNT16_W-1:0]),
    .kind(shiftKind),
    .result(shiftWord)
  );

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gByteShift
      // Same count for both lanes, taken from the low bits only
      swa_shift_lane #(.W(B), .CW(swa_pkg::CNT8_W)) uShiftByte (
        .value(firstSourceOperand[g*B +: B]),
        .count(secondSourceOperand[swa_pkg::CNT8_W-1:0]),
        .kind(shiftKind),
        .result(shiftBytes[g*B +: B])
      );
    end
  endgenerate

  // ==========================================================
  // Multiply-accumulate
  logic [B-1:0] macA;
  logic [B-1:0] macB;
  logic [W-1:0] product;
  logic [W:0] macFull;
  always_comb begin
    if (issueOp == swa_pkg::OP_HIGH_BYTE_MULTIPLY_ACCUMULATE) begin
      macA = firstSourceOperand[W-1:B];
      macB = secondSourceOperand[W-1:B];
    end else begin
      macA = firstSourceOperand[B-1:0];
      macB = secondSourceOperand[B-1:0];
    end
    // An 8 by 8 product always fits the word, so only the add can overflow
    product = {{B{1'b0}}, macA} * {{B{1'b0}}, macB};
    macFull = {1'b0, destOperand} + {1'b0, product};
  end

  // ==========================================================
  // Result and flag selection
  logic [swa_pkg::FLAG_W-1:0] flags_q [THREADS];
  logic [swa_pkg::FLAG_W-1:0] flagCur;
  logic [swa_pkg::FLAG_W-1:0] flagNext;
  logic [W-1:0] aluOut;
  logic writesDest;

  always_comb begin
    flagCur = flags_q[issueThread];
    flagNext = flagCur;
    aluOut = {hiSum, loSum};
    writesDest = 1'b1;
    unique case (issueOp)
      swa_pkg::OP_SUM: begin
        aluOut = {hiSum, loSum};
        if (byteMode) begin
          flagNext[F6] = loOver;
          flagNext[F7] = hiOver;
        end else begin
          flagNext[F6] = hiOver;
        end
      end
      swa_pkg::OP_DIFFERENCE: begin
        aluOut = {hiSum, loSum};
        if (byteMode) begin
          flagNext[F6] = loOver;
          flagNext[F7] = hiOver;
        end else begin
          flagNext[F6] = hiOver;
        end
      end
      swa_pkg::OP_SUBWORD_AVERAGE: begin
        // Carry kept as the top bit so the halved sum never loses it
        if (byteMode) begin
          aluOut = {hiCout, hiSum[B-1:1], loCout, loSum[B-1:1]};
          flagNext[F7] = 1'b0;
        end else begin
          aluOut = {hiCout, hiSum, loSum[B-1:1]};
        end
        flagNext[F6] = 1'b0;
      end
      swa_pkg::OP_SUBWORD_DIFFERENCE_HALVED: begin
        // Wrapped difference shifted logically, per the wraparound rule
        if (byteMode) begin
          aluOut = {1'b0, hiSum[B-1:1], 1'b0, loSum[B-1:1]};
          flagNext[F6] = loOver;
          flagNext[F7] = hiOver;
        end else begin
          aluOut = {1'b0, hiSum, loSum[B-1:1]};
          flagNext[F6] = hiOver;
        end
      end
      swa_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
        aluOut = byteMode ? shiftBytes : shiftWord;
      end
      swa_pkg::OP_ARITH_RIGHT_SHIFT: begin
        aluOut = byteMode ? shiftBytes : shiftWord;
      end
      swa_pkg::OP_LOGICAL_LEFT_SHIFT: begin
        aluOut = byteMode ? shiftBytes : shiftWord;
      end
      swa_pkg::OP_ROTATE_LEFT: begin
        // Flags untouched: flagNext still holds the current byte
        aluOut = byteMode ? shiftBytes : shiftWord;
      end
      swa_pkg::OP_LOW_BYTE_MULTIPLY_ACCUMULATE: begin
        aluOut = macFull[W-1:0];
        flagNext[F6] = macFull[W];
      end
      swa_pkg::OP_HIGH_BYTE_MULTIPLY_ACCUMULATE: begin
        aluOut = macFull[W-1:0];
        flagNext[F6] = macFull[W];
      end
      swa_pkg::OP_NONE: begin
        writesDest = 1'b0;
      end
      swa_pkg::OP_FLAG_WRITE: begin
        // Whole byte loaded by software; bit 0 is forced again below
        flagNext = flagWriteData;
        writesDest = 1'b0;
      end
      default: begin
        // Unused codes act as no-ops so a stray code cannot disturb state
        writesDest = 1'b0;
      end
    endcase
    flagNext[swa_pkg::FLAG_ALWAYS_ONE] = 1'b1;
  end

  // ==========================================================
  // Per-thread flag registers
  // A low clock enable freezes every register; an op offered then is dropped
  logic [swa_pkg::FLAG_W-1:0] flags_d [THREADS];
  always_comb begin
    for (int t = 0; t < THREADS; t++) begin
      flags_d[t] = flags_q[t];
    end
    if (issueValid) begin
      flags_d[issueThread] = flagNext;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int t = 0; t < THREADS; t++) begin
        flags_q[t] <= swa_pkg::FLAG_RESET;
      end
    end else if (clkEn) begin
      for (int t = 0; t < THREADS; t++) begin
        flags_q[t] <= flags_d[t];
      end
    end
  end

  // ==========================================================
  // Flag read port
  // Shows the stored byte, so an op issued this cycle appears one cycle later
  assign flagReadData = flags_q[flagReadThread];

  // ==========================================================
  // Registered result
  // Data and thread hold between writing ops; only the write strobe pulses
  logic [W-1:0] resultData_d;
  logic [W-1:0] resultData_q;
  logic resultWrite_d;
  logic resultWrite_q;
  logic [swa_pkg::TID_W-1:0] resultThread_d;
  logic [swa_pkg::TID_W-1:0] resultThread_q;

  always_comb begin
    resultData_d = resultData_q;
    resultThread_d = resultThread_q;
    resultWrite_d = issueValid && writesDest;
    if (issueValid && writesDest) begin
      resultData_d = aluOut;
      resultThread_d = issueThread;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      resultData_q <= swa_pkg::RESULT_RESET;
      resultWrite_q <= 1'b0;
      resultThread_q <= swa_pkg::THREAD_RESET;
    end else if (clkEn) begin
      resultData_q <= resultData_d;
      resultWrite_q <= resultWrite_d;
      resultThread_q <= resultThread_d;
    end
  end

  assign resultData = resultData_q;
  assign resultWrite = resultWrite_q;
  assign resultThread = resultThread_q;
endmodule

// >>> rtl/swa_pkg.sv
// Shared constants and types for the subword ALU with flags.
// Assumes a four-thread interleaved pipeline supplies operands and thread id.
package swa_pkg;
  // ==========================================================
  // Widths
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int FLAG_W = 8;
  localparam int THREADS = 4;
  localparam int TID_W = 2;
  // ==========================================================
  // Flag layout
  localparam int FLAG_ALWAYS_ONE = 0;
  localparam int FLAG_LOW_CARRY = 6;
  localparam int FLAG_HIGH_CARRY = 7;
  localparam logic [7:0] FLAG_RESET = 8'h01;
  // ==========================================================
  // Reset values of the registered result
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [1:0] THREAD_RESET = 2'h0;
  // ==========================================================
  // Shift count widths per lane size
  localparam int CNT8_W = 3;
  localparam int CNT16_W = 4;
  // ==========================================================
  // Operation codes
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SUM = 4'h1,
    OP_DIFFERENCE = 4'h2,
    OP_SUBWORD_AVERAGE = 4'h3,
    OP_SUBWORD_DIFFERENCE_HALVED = 4'h4,
    OP_LOGICAL_RIGHT_SHIFT = 4'h5,
    OP_ARITH_RIGHT_SHIFT = 4'h6,
    OP_LOGICAL_LEFT_SHIFT = 4'h7,
    OP_ROTATE_LEFT = 4'h8,
    OP_LOW_BYTE_MULTIPLY_ACCUMULATE = 4'h9,
    OP_HIGH_BYTE_MULTIPLY_ACCUMULATE = 4'hA,
    OP_FLAG_WRITE = 4'hB
  } swa_op_t;
endpackage

// >>> rtl/swa_lane.sv
// One 8-bit lane of add/subtract/average arithmetic with carry-out.
// Assumes the caller chains two lanes and picks the carry-in for 16-bit mode.
`timescale 1ns/100ps
module swa_lane #(
  parameter int W = 8
) (
  input wire logic [W-1:0] laneA,
  input wire logic [W-1:0] laneB,
  input wire logic subtract,
  input wire logic carryIn,
  output logic [W-1:0] sum,
  output logic carryOut
);
  logic [W:0] full;
  // Subtract as A + ~B + cin; caller gives cin = 1 for the lowest lane
  always_comb begin
    full = {1'b0, laneA} + {1'b0, (subtract ? ~laneB : laneB)} + {{W{1'b0}}, carryIn};
    sum = full[W-1:0];
    carryOut = full[W];
  end
endmodule

// >>> rtl/swa_shift_lane.sv
// Shift and rotate of one operand slice, width set by parameter.
// Assumes the count is already trimmed to the lane's count width.
`timescale 1ns/100ps
module swa_shift_lane #(
  parameter int W = 8,
  parameter int CW = 3
) (
  input wire logic [W-1:0] value,
  input wire logic [CW-1:0] count,
  input wire logic [1:0] kind,
  output logic [W-1:0] result
);
  logic [2*W-1:0] doubled;
  always_comb begin
    doubled = {value, value} << count;
    unique case (kind)
      2'h0: result = value >> count;
      2'h1: result = W'($signed(value) >>> count);
      2'h2: result = value << count;
      2'h3: result = doubled[2*W-1:W];
    endcase
  end
endmodule

// >>> dv/swa_alu_assertions.sv
// Port checks on the execute stage.
// Flags 6 and 7 are judged only when the read port shows the last issuer; bit 0 is judged every cycle.
`timescale 1ns/100ps
module swa_alu_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic issueValid,
  input wire logic [1:0] issueThread,
  input wire swa_pkg::swa_op_t issueOp,
  input wire logic byteMode,
  input wire logic [15:0] firstSourceOperand,
  input wire logic [15:0] secondSourceOperand,
  input wire logic [15:0] destOperand,
  input wire logic [1:0] flagReadThread,
  input wire logic [15:0] resultData,
  input wire logic resultWrite,
  input wire logic [7:0] flagReadData
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic [1:0] thr_q;
  wire [15:0] a = firstSourceOperand;
  wire [15:0] b = secondSourceOperand;
  wire [16:0] s = a + b;
  wire [16:0] d = a - b;
  wire [16:0] m = destOperand + a[7:0] * b[7:0];
  wire [8:0] sl = a[7:0] + b[7:0];
  wire [8:0] sh = a[15:8] + b[15:8];
  wire go = issueValid & clkEn;
  wire w = go & !byteMode;
  wire x = go & byteMode;
  wire f = flagReadThread == thr_q;
  always_ff @(posedge sys_clk) thr_q <= issueThread;
  sum_word_a: assert property (w && issueOp == swa_pkg::OP_SUM |=>
    resultWrite && resultData == $past(s[15:0]) && (!f || flagReadData[6] == $past(s[16])))
    else $error("word sum");
  sum_byte_a: assert property (x && issueOp == swa_pkg::OP_SUM |=>
    resultData == $past({sh[7:0], sl[7:0]}) && (!f || flagReadData[7:6] == $past({sh[8], sl[8]})))
    else $error("byte sum");
  diff_word_a: assert property (w && issueOp == swa_pkg::OP_DIFFERENCE |=>
    resultData == $past(d[15:0]) && (!f || flagReadData[6] == $past(d[16])))
    else $error("word difference");
  avg_word_a: assert property (w && issueOp == swa_pkg::OP_SUBWORD_AVERAGE |=>
    resultData == $past(s[16:1]) && (!f || !flagReadData[6]))
    else $error("word average");
  halved_word_a: assert property (w && issueOp == swa_pkg::OP_SUBWORD_DIFFERENCE_HALVED |=>
    resultData == $past({1'b0, d[15:1]}) && (!f || flagReadData[6] == $past(d[16])))
    else $error("word halved");
  lsl_byte_a: assert property (x && issueOp == swa_pkg::OP_LOGICAL_LEFT_SHIFT |=>
    resultData == $past({a[15:8] << b[2:0], a[7:0] << b[2:0]}))
    else $error("byte left shift");
  mac_low_a: assert property (go && issueOp == swa_pkg::OP_LOW_BYTE_MULTIPLY_ACCUMULATE |=>
    resultData == $past(m[15:0]) && (!f || flagReadData[6] == $past(m[16])))
    else $error("low accumulate");
  flag_one_a: assert property (flagReadData[0]) else $error("flag bit zero");
  cover property (w && issueOp == swa_pkg::OP_SUM);
  cover property (x && issueOp == swa_pkg::OP_SUBWORD_AVERAGE);
  cover property (go && issueOp == swa_pkg::OP_HIGH_BYTE_MULTIPLY_ACCUMULATE);
endmodule
bind swa_alu swa_alu_checker u_chk (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .clkEn(clkEn),
  .issueValid(issueValid),
  .issueThread(issueThread),
  .issueOp(issueOp),
  .byteMode(byteMode),
  .firstSourceOperand(firstSourceOperand),
  .secondSourceOperand(secondSourceOperand),
  .destOperand(destOperand),
  .flagReadThread(flagReadThread),
  .resultData(resultData),
  .resultWrite(resultWrite),
  .flagReadData(flagReadData)
);

// >>> dv/swa_pipe_model.sv
// Register file stand-in: one destination word per thread.
// Results arrive tagged with their thread and feed later accumulates.
`timescale 1ns/100ps
module swa_pipe_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic resultWrite,
  input wire logic [1:0] resultThread,
  input wire logic [15:0] resultData,
  input wire logic [1:0] issueThread,
  output logic [15:0] destOperand
);
  logic [15:0] dest_q [4];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) dest_q <= '{default: 16'h0000};
    else if (resultWrite) dest_q[resultThread] <= resultData;
  end
  assign destOperand = dest_q[issueThread];
endmodule

// >>> dv/testbench.sv
// Corner cases then seeded random ops, issued back to back.
// Result and flags are read one cycle after each issue.
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, issueValid = 1'b0, byteMode = 1'b0;
  logic [1:0] issueThread = '0, flagReadThread = '0, resultThread, pendT = '0;
  swa_pkg::swa_op_t issueOp = swa_pkg::OP_NONE;
  logic [15:0] firstSourceOperand = '0, secondSourceOperand = '0, destOperand, resultData;
  logic [7:0] flagWriteData = '0, flagReadData;
  logic resultWrite;
  logic [7:0] flg [4] = '{default: 8'h01};
  logic [24:0] pend = '0;
  logic [31:0] seed = 32'hA098;
  int errCount = 0, numChecks = 0, cyc = 0;
  swa_alu u_dut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .issueValid(issueValid),
    .issueThread(issueThread),
    .issueOp(issueOp),
    .byteMode(byteMode),
    .firstSourceOperand(firstSourceOperand),
    .secondSourceOperand(secondSourceOperand),
    .destOperand(destOperand),
    .flagWriteData(flagWriteData),
    .flagReadThread(flagReadThread),
    .resultData(resultData),
    .resultWrite(resultWrite),
    .resultThread(resultThread),
    .flagReadData(flagReadData)
  );
  swa_pipe_model u_model (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .resultWrite(resultWrite),
    .resultThread(resultThread),
    .resultData(resultData),
    .issueThread(issueThread),
    .destOperand(destOperand)
  );
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      errCount++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(string nm, logic [24:0] seen, logic [24:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] lane(logic [15:0] v, int c, int k, int n);
    logic [31:0] m, x;
    m = (32'h1 << n) - 1;
    x = v & m;
    if (k == 1 && x[n-1]) x = x | ~m;
    case (k)
      0, 1: x = x >> c;
      2: x = x << c;
      default: x = (x << c) | (x >> (n - c));
    endcase
    return 16'(x & m);
  endfunction
  function automatic logic [24:0] expect_op(swa_pkg::swa_op_t op, logic bm,
      logic [15:0] a, logic [15:0] b, logic [15:0] d, logic [7:0] f, logic [7:0] fw);
    logic [16:0] r;
    logic [8:0] lo, hi;
    logic [15:0] res;
    logic sub;
    sub = op == swa_pkg::OP_DIFFERENCE || op == swa_pkg::OP_SUBWORD_DIFFERENCE_HALVED;
    r = sub ? a - b : a + b;
    lo = sub ? a[7:0] - b[7:0] : a[7:0] + b[7:0];
    hi = sub ? a[15:8] - b[15:8] : a[15:8] + b[15:8];
    res = bm ? {hi[7:0], lo[7:0]} : r[15:0];
    case (op)
      swa_pkg::OP_SUM, swa_pkg::OP_DIFFERENCE, swa_pkg::OP_SUBWORD_DIFFERENCE_HALVED: begin
        f[6] = bm ? lo[8] : r[16];
        if (bm) f[7] = hi[8];
        if (sub && op != swa_pkg::OP_DIFFERENCE) res = bm ? {1'b0, hi[7:1], 1'b0, lo[7:1]} :
          {1'b0, r[15:1]};
      end
      swa_pkg::OP_SUBWORD_AVERAGE: begin
        res = bm ? {hi[8:1], lo[8:1]} : r[16:1];
        f[6] = 1'b0;
        if (bm) f[7] = 1'b0;
      end
      swa_pkg::OP_LOW_BYTE_MULTIPLY_ACCUMULATE, swa_pkg::OP_HIGH_BYTE_MULTIPLY_ACCUMULATE: begin
        r = op[0] ? d + a[7:0] * b[7:0] : d + a[15:8] * b[15:8];
        res = r[15:0];
        f[6] = r[16];
      end
      swa_pkg::OP_FLAG_WRITE: return {1'b0, fw | 8'h01, res};
      swa_pkg::OP_NONE: return {1'b0, f, res};
      default: res = bm ? (lane(a >> 8, b[2:0], int'(op) - 5, 8) << 8) |
        lane(a, b[2:0], int'(op) - 5, 8) : lane(a, b[3:0], int'(op) - 5, 16);
    endcase
    return {1'b1, f, res};
  endfunction
  // Each call issues the next op, then checks the previous one
  task automatic step(swa_pkg::swa_op_t op, logic bm, logic [15:0] a, logic [15:0] b,
      logic [1:0] t, logic v = 1'b1, logic [7:0] fw = 8'h00, logic en = 1'b1);
    @(posedge sys_clk);
    clkEn <= en;
    issueOp <= op;
    byteMode <= bm;
    firstSourceOperand <= a;
    secondSourceOperand <= b;
    issueThread <= t;
    issueValid <= v;
    flagWriteData <= fw;
    flagReadThread <= pendT;
    #1;
    check("write", resultWrite, pend[24]);
    if (pend[24]) check("data", {resultThread, resultData}, {pendT, pend[15:0]});
    check("flags", flagReadData, flg[pendT]);
    // A frozen cycle takes nothing, so the held result is expected once more
    if (en) begin
      pend = v ? expect_op(op, bm, a, b, destOperand, flg[t], fw) : {1'b0, flg[t], 16'h0000};
      flg[t] = pend[23:16];
      pendT = t;
    end
  endtask
  initial begin
    logic [31:0] r;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    step(swa_pkg::OP_SUM, 1'b0, 16'hFFFF, 16'h0002, 2'h0);
    step(swa_pkg::OP_SUM, 1'b1, 16'hFF80, 16'h0180, 2'h1);
    step(swa_pkg::OP_SUBWORD_AVERAGE, 1'b1, 16'hFFFF, 16'hFFFF, 2'h1);
    step(swa_pkg::OP_SUBWORD_DIFFERENCE_HALVED, 1'b1, 16'h0001, 16'h0203, 2'h3);
    step(swa_pkg::OP_ARITH_RIGHT_SHIFT, 1'b1, 16'h8040, 16'h00FF, 2'h0);
    step(swa_pkg::OP_ROTATE_LEFT, 1'b0, 16'h8001, 16'h001F, 2'h0);
    step(swa_pkg::OP_HIGH_BYTE_MULTIPLY_ACCUMULATE, 1'b0, 16'hFFFF, 16'hFFFF, 2'h0);
    step(swa_pkg::OP_FLAG_WRITE, 1'b0, 16'h0000, 16'h0000, 2'h0, 1'b1, 8'hFE, 1'b0);
    step(swa_pkg::OP_FLAG_WRITE, 1'b0, 16'h0000, 16'h0000, 2'h1, 1'b1, 8'hC0);
    $display("test corners done");
    for (int i = 0; i < 3000; i++) begin
      r = rnd();
      step(swa_pkg::swa_op_t'(4'(r % 12)), r[4], 16'(rnd()), 16'(rnd()), r[6:5], r[9:7] != 0,
        r[31:24], r[11:10] != 0);
    end
    step(swa_pkg::OP_NONE, 1'b0, 16'h0000, 16'h0000, 2'h0);
    $display("test random done");
    conclude();
  end
endmodule
